// >>> logic/dvps_top.sv
// Code-change handling, transient sequencing and phase shuffling of a buck controller.
`timescale 1ns/10ps
module dvps_top #(
  parameter int NUM_PHASES = 6
) (
  // Clock and reset
  input  wire logic                           CLOCK,
  input  wire logic                           RST,
  // Enable and supply pins
  input  wire logic                           EN_ABOVE_THRESHOLD,
  input  wire logic                           SUPPLY_LOCKOUT,
  // Identification code pins
  input  wire logic [dvps_pkg::CODE_W-1:0]    VOLTAGE_IDENT_CODE,
  // Analog comparator levels
  input  wire logic                           LOAD_STEP_UP,
  input  wire logic                           LOAD_RELEASE,
  input  wire logic                           OUTPUT_IN_RANGE,
  input  wire logic                           OUTPUT_OVER_CLAMP,
  // Phase and driver outputs
  output logic      [NUM_PHASES-1:0]          PHASE_DRIVE,
  output logic                                CORE_PHASE_DISABLE_N,
  output logic                                SHED_PHASE_DISABLE_N,
  // Status outputs
  output logic                                OUTPUT_IN_RANGE_FLAG,
  output logic                                CLAMP_ACTIVE,
  output logic                                LOAD_RELEASE_FLAG,
  output logic                                BLANKING_ACTIVE,
  output logic      [dvps_pkg::CODE_W-1:0]    CODE_TARGET
);
  // --------------------------------------------------------------------------
  // Local widths and limits
  // --------------------------------------------------------------------------
  localparam int CW   = dvps_pkg::CODE_W;
  localparam int PW   = $clog2(NUM_PHASES);
  localparam int SW   = CW + 6;
  localparam int DGW  = $clog2(dvps_pkg::DEGLITCH_CYC + 1);
  localparam int BW   = $clog2(dvps_pkg::BLANK_CYC + 1);
  localparam int OW   = $clog2(dvps_pkg::OFF_CYC);
  localparam int TW   = $clog2(dvps_pkg::SLOT_CYC);
  localparam int KW   = $clog2(dvps_pkg::STEP_CYC);
  localparam logic [DGW-1:0] DG_LAST    = DGW'(dvps_pkg::DEGLITCH_CYC - 1);
  localparam logic [DGW-1:0] DG_FULL    = DGW'(dvps_pkg::DEGLITCH_CYC);
  localparam logic [BW-1:0]  BLANK_FULL = BW'(dvps_pkg::BLANK_CYC);
  localparam logic [OW-1:0]  OFF_LAST   = OW'(dvps_pkg::OFF_CYC - 1);
  localparam logic [TW-1:0]  SLOT_LAST  = TW'(dvps_pkg::SLOT_CYC - 1);
  localparam logic [TW-1:0]  ON_LEN     = TW'(dvps_pkg::ON_CYC);
  localparam logic [KW-1:0]  STEP_LAST  = KW'(dvps_pkg::STEP_CYC - 1);
  localparam logic [PW-1:0]  PH_LAST    = PW'(NUM_PHASES - 1);

  // Refuses phase counts the order keeper and the slot counter cannot serve.
  if (NUM_PHASES < 2 || NUM_PHASES > 8) begin : g_bad_phases
    $error("NUM_PHASES must lie between 2 and 8");
  end

  logic [SW-1:0]           s1_r;
  logic [SW-1:0]           s2_r;
  logic                    en_s, lock_s, step_s, rel_s, inr_s, over_s;
  logic [CW-1:0]           code_s;
  logic [CW-1:0]           code_prev_r;
  logic                    rel_prev_r;
  logic                    code_chg, load, running, blanking, off_done;
  logic                    blanking_r;
  dvps_pkg::dvps_state_type st_r, st_nxt;
  logic [DGW-1:0]          dg_cnt_r, dg_cnt_nxt;
  logic [CW-1:0]           target_r, target_nxt;
  logic [BW-1:0]           blank_cnt_r, blank_cnt_nxt;
  logic [OW-1:0]           off_cnt_r, off_cnt_nxt;
  logic [TW-1:0]           slot_tmr_r, slot_tmr_nxt;
  logic [PW-1:0]           slot_r, slot_nxt;
  logic [KW-1:0]           step_tmr_r, step_tmr_nxt;
  logic [PW-1:0]           extra_r, extra_nxt;
  logic                    shuffle_r, shuffle_nxt;
  logic [NUM_PHASES-1:0]   drive_r, drive_nxt;
  logic                    inr_r, inr_nxt, clamp_r, clamp_nxt;
  logic                    relf_r, relf_nxt, dis_n_r, dis_n_nxt;

  dvps_phase_if #(.N(NUM_PHASES), .PW(PW)) ph_bus ();

  dvps_shuffle #(.N(NUM_PHASES), .PW(PW)) u_shuf (
    .clock (CLOCK),
    .rst   (RST),
    .bus   (ph_bus.shuf)
  );

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // Two stages for every pin; only the second stage is read by logic.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= {EN_ABOVE_THRESHOLD, SUPPLY_LOCKOUT, LOAD_STEP_UP, LOAD_RELEASE,
               OUTPUT_IN_RANGE, OUTPUT_OVER_CLAMP, VOLTAGE_IDENT_CODE};
      s2_r <= s1_r;
    end
  end

  // Unpacks the synchronised pins and derives the shared conditions.
  assign {en_s, lock_s, step_s, rel_s, inr_s, over_s, code_s} = s2_r;
  assign code_chg = code_s != code_prev_r;
  assign load     = !code_chg && (dg_cnt_r == DG_LAST);
  assign running  = st_r == dvps_pkg::ST_RUN;
  assign blanking = blank_cnt_r != '0;
  assign off_done = running && !code_chg && code_s == dvps_pkg::OFF_CODE && off_cnt_r == OFF_LAST;

  // --------------------------------------------------------------------------
  // Operating state, code deglitch, blanking and off-code timers
  // --------------------------------------------------------------------------
  always_comb begin
    st_nxt        = st_r;
    dg_cnt_nxt    = dg_cnt_r;
    target_nxt    = target_r;
    blank_cnt_nxt = blank_cnt_r;
    off_cnt_nxt   = '0;
    if (!en_s || lock_s) begin
      st_nxt = dvps_pkg::ST_IDLE;
    end else begin
      case (st_r)
        dvps_pkg::ST_IDLE: st_nxt = dvps_pkg::ST_RUN;
        dvps_pkg::ST_RUN: begin
          if (off_done) begin
            st_nxt = dvps_pkg::ST_SHUT;
          end
        end
        dvps_pkg::ST_SHUT: st_nxt = dvps_pkg::ST_SHUT;
        default: st_nxt = dvps_pkg::ST_IDLE;
      endcase
    end
    // A changing bit restarts the quiet window; the code is taken at its end.
    if (code_chg) begin
      dg_cnt_nxt = '0;
    end else if (load) begin
      dg_cnt_nxt = DG_FULL;
      target_nxt = code_s;
    end else if (dg_cnt_r != DG_FULL) begin
      dg_cnt_nxt = dg_cnt_r + 1'b1;
    end
    // Every change while running loads the full blanking time again.
    if (running && code_chg) begin
      blank_cnt_nxt = BLANK_FULL;
    end else if (blanking) begin
      blank_cnt_nxt = blank_cnt_r - 1'b1;
    end
    // The off code must stand unchanged before shutdown.
    if (running && !code_chg && code_s == dvps_pkg::OFF_CODE && off_cnt_r != OFF_LAST) begin
      off_cnt_nxt = off_cnt_r + 1'b1;
    end else if (off_done) begin
      off_cnt_nxt = off_cnt_r;
    end
  end

  // Registers the state and timers.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st_r        <= dvps_pkg::ST_IDLE;
      code_prev_r <= '0;
      dg_cnt_r    <= '0;
      target_r    <= '0;
      blank_cnt_r <= '0;
      off_cnt_r   <= '0;
    end else begin
      st_r        <= st_nxt;
      code_prev_r <= code_s;
      dg_cnt_r    <= dg_cnt_nxt;
      target_r    <= target_nxt;
      blank_cnt_r <= blank_cnt_nxt;
      off_cnt_r   <= off_cnt_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Phase slots, step-up sequencing and outputs
  // --------------------------------------------------------------------------
  always_comb begin
    slot_tmr_nxt = slot_tmr_r + 1'b1;
    slot_nxt     = slot_r;
    step_tmr_nxt = '0;
    extra_nxt    = '0;
    if (slot_tmr_r == SLOT_LAST) begin
      slot_tmr_nxt = '0;
      slot_nxt     = (slot_r == PH_LAST) ? '0 : slot_r + 1'b1;
    end
    // Held step-up adds one more phase every step interval.
    if (running && step_s) begin
      extra_nxt = extra_r;
      if (step_tmr_r == STEP_LAST) begin
        if (extra_r != PH_LAST) begin
          extra_nxt = extra_r + 1'b1;
        end
      end else begin
        step_tmr_nxt = step_tmr_r + 1'b1;
      end
    end
    shuffle_nxt = running && rel_s && !rel_prev_r;
    // The change that starts blanking is itself blanked, so no monitor slips through.
    clamp_nxt   = running && !blanking && !code_chg && over_s;
    inr_nxt     = running && ((blanking || code_chg) ? inr_r : inr_s);
    relf_nxt    = running && rel_s;
    dis_n_nxt   = running;
    drive_nxt   = '0;
    if (running && !clamp_r && slot_tmr_r < ON_LEN) begin
      drive_nxt = ph_bus.fire;
    end
  end

  // Registers slot, sequencing and the drive, enable and monitor outputs.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      slot_tmr_r <= '0;
      slot_r     <= '0;
      step_tmr_r <= '0;
      extra_r    <= '0;
      rel_prev_r <= 1'b0;
      shuffle_r  <= 1'b0;
      drive_r    <= '0;
      inr_r      <= 1'b0;
      clamp_r    <= 1'b0;
      relf_r     <= 1'b0;
      dis_n_r    <= 1'b0;
    end else begin
      slot_tmr_r <= slot_tmr_nxt;
      slot_r     <= slot_nxt;
      step_tmr_r <= step_tmr_nxt;
      extra_r    <= extra_nxt;
      rel_prev_r <= rel_s;
      shuffle_r  <= shuffle_nxt;
      drive_r    <= drive_nxt;
      inr_r      <= inr_nxt;
      clamp_r    <= clamp_nxt;
      relf_r     <= relf_nxt;
      dis_n_r    <= dis_n_nxt;
    end
  end

  // Drives the carrier and the ports from registers.
  assign ph_bus.shuffle       = shuffle_r;
  assign ph_bus.slot          = slot_r;
  assign ph_bus.extra         = extra_r;
  assign PHASE_DRIVE          = drive_r;
  assign CORE_PHASE_DISABLE_N = dis_n_r;
  assign SHED_PHASE_DISABLE_N = dis_n_r;
  assign OUTPUT_IN_RANGE_FLAG = inr_r;
  assign CLAMP_ACTIVE         = clamp_r;
  assign LOAD_RELEASE_FLAG    = relf_r;
  assign BLANKING_ACTIVE      = blanking_r;
  assign CODE_TARGET          = target_r;

  // Registered copy of the blanking condition for the status pin.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      blanking_r <= 1'b0;
    end else begin
      blanking_r <= blank_cnt_nxt != '0;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  property p_ignore; code_chg |=> $stable(target_r)[*8]; endproperty
  a_ignore: assert property (p_ignore) else $error("target moved in deglitch");
  property p_quiet; $changed(target_r) |-> $past(dg_cnt_r) == DG_LAST; endproperty
  a_quiet: assert property (p_quiet) else $error("target loaded early");
  property p_take; running && load |=> target_r == $past(code_s); endproperty
  a_take: assert property (p_take) else $error("code not taken");
  property p_blank;
    running && code_chg && !blanking |=> blank_cnt_r == BLANK_FULL ##1 blanking[*8];
  endproperty
  a_blank: assert property (p_blank) else $error("blanking not started");
  property p_hold;
    running && (blanking || code_chg) |=> !CLAMP_ACTIVE && $stable(OUTPUT_IN_RANGE_FLAG);
  endproperty
  a_hold: assert property (p_hold) else $error("monitor reported while blanked");
  property p_restart; running && code_chg && blanking |=> blank_cnt_r == BLANK_FULL; endproperty
  a_restart: assert property (p_restart) else $error("blanking not restarted");
  property p_shut;
    $rose(st_r == dvps_pkg::ST_SHUT) |-> $past(off_cnt_r) == OFF_LAST && $past(running);
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown without confirm");
  property p_step;
    running && step_s && step_tmr_r == STEP_LAST && extra_r != PH_LAST
      |=> extra_r == $past(extra_r) + 1'b1;
  endproperty
  a_step: assert property (p_step) else $error("phase not added");
  property p_rel; running && rel_s |=> LOAD_RELEASE_FLAG; endproperty
  a_rel: assert property (p_rel) else $error("release flag missing");
  property p_shuf;
    running && rel_s && !rel_prev_r |=> ph_bus.shuffle ##1 !ph_bus.shuffle;
  endproperty
  a_shuf: assert property (p_shuf) else $error("no shuffle on release");
  property p_off;
    !en_s || lock_s |-> ##2 PHASE_DRIVE == '0 && !OUTPUT_IN_RANGE_FLAG && !CORE_PHASE_DISABLE_N;
  endproperty
  a_off: assert property (p_off) else $error("outputs active while disabled");
  c_restart: cover property (running && code_chg && blanking);
  c_shut: cover property ($rose(st_r == dvps_pkg::ST_SHUT));
  c_shuffle: cover property (ph_bus.shuffle);
  c_all: cover property (running && extra_r == PH_LAST);
endmodule

// >>> logic/dvps_pkg.sv
// Shared constants and types of the code-change and phase-shuffle sequencer.
package dvps_pkg;
  // --------------------------------------------------------------------------
  // Clock and timing
  // --------------------------------------------------------------------------
  localparam int CLK_MHZ      = 40;
  localparam int DEGLITCH_NS  = 200;
  localparam int DEGLITCH_CYC = (DEGLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_US     = 100;
  localparam int BLANK_CYC    = BLANK_US * CLK_MHZ;
  localparam int OFF_US       = 5;
  localparam int OFF_CYC      = OFF_US * CLK_MHZ;
  localparam int SLOT_CYC     = 16;
  localparam int ON_CYC       = 6;
  localparam int STEP_CYC     = 4;
  // --------------------------------------------------------------------------
  // Codes and seeds
  // --------------------------------------------------------------------------
  localparam int                 CODE_W    = 8;
  localparam logic [CODE_W-1:0]  OFF_CODE  = 8'h00;
  localparam logic [15:0]        LFSR_SEED = 16'hace1;
  localparam logic [15:0]        LFSR_TAPS = 16'hb400;
  // Controller operating state.
  typedef enum {ST_IDLE, ST_RUN, ST_SHUT} dvps_state_type;
endpackage

// >>> logic/dvps_phase_if.sv
// Carrier between the sequencer and its phase order keeper.
`timescale 1ns/10ps
interface dvps_phase_if #(parameter int N = 6, parameter int PW = 3);
  logic          shuffle;
  logic [PW-1:0] slot;
  logic [PW-1:0] extra;
  logic [N-1:0]  fire;
  modport main (output shuffle, output slot, output extra, input fire);
  modport shuf (input shuffle, input slot, input extra, output fire);
endinterface

// >>> logic/dvps_shuffle.sv
// Phase order keeper: holds each phase's firing position and reshuffles it.
`timescale 1ns/10ps
module dvps_shuffle #(
  parameter int N  = 6,
  parameter int PW = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Sequencer side
  dvps_phase_if.shuf bus
);
  logic [PW-1:0] pos_r   [N];
  logic [PW-1:0] pos_nxt [N];
  logic [15:0]   lfsr_r;
  logic [15:0]   lfsr_nxt;
  logic [PW-1:0] idx_a;
  logic [PW-1:0] idx_b;

  // --------------------------------------------------------------------------
  // Random swap of two positions
  // --------------------------------------------------------------------------
  // The generator runs every cycle, so the moment of a release picks the swap.
  always_comb begin
    lfsr_nxt = {lfsr_r[14:0], ^(lfsr_r & dvps_pkg::LFSR_TAPS)};
    idx_a    = PW'(int'(lfsr_r[7:0]) % N);
    idx_b    = PW'((int'(idx_a) + 1 + int'(lfsr_r[15:8]) % (N - 1)) % N);
    pos_nxt  = pos_r;
    if (bus.shuffle) begin
      pos_nxt[idx_a] = pos_r[idx_b];
      pos_nxt[idx_b] = pos_r[idx_a];
    end
  end

  // Registers the order; reset gives phase p position p.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lfsr_r <= dvps_pkg::LFSR_SEED;
      for (int i = 0; i < N; i++) begin
        pos_r[i] <= PW'(i);
      end
    end else begin
      lfsr_r <= lfsr_nxt;
      pos_r  <= pos_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Fire mask: the slot's phase plus the next extra ones in order
  // --------------------------------------------------------------------------
  for (genvar p = 0; p < N; p++) begin : g_fire
    assign bus.fire[p] = ((int'(pos_r[p]) + N - int'(bus.slot)) % N) <= int'(bus.extra);
  end
endmodule

// >>> bench/dvps_proc_model.sv
// Processor model that drives the identification code pins of the sequencer.
`timescale 1ns/10ps
module dvps_proc_model (
  // Clock
  input  wire logic                        clock,
  // Code pins
  output logic      [dvps_pkg::CODE_W-1:0] code
);
  // The start code is a running code, so no shutdown is confirmed at power-up.
  initial begin
    code = 8'h40;
  end

  // Moves the code to its finish value in one step, just after a falling edge.
  task automatic step(input logic [dvps_pkg::CODE_W-1:0] c);
    @(negedge clock);
    code = c;
  endtask

  // Moves the code one bit at a time, gap cycles apart, as skewed processor pins do.
  task automatic walk(input logic [dvps_pkg::CODE_W-1:0] c, input int gap);
    for (int b = 0; b < dvps_pkg::CODE_W; b++) begin
      if (code[b] !== c[b]) begin
        repeat (gap) @(negedge clock);
        code[b] = c[b];
      end
    end
  endtask
endmodule

// >>> bench/dvps_tb_top.sv
// Self-checking testbench of the code-change and phase-shuffle sequencer.
`timescale 1ns/10ps
module dvps_tb_top;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  localparam int NP = 6;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          en = 1'b1;
  logic          lock = 1'b0;
  logic          step = 1'b0;
  logic          rel = 1'b0;
  logic          inr = 1'b1;
  logic          ovc = 1'b0;
  logic [7:0]    code;
  logic [NP-1:0] pd;
  logic          core_n, shed_n, flag, clamp, rflag, blank;
  logic [7:0]    tgt;
  int            miscompares = 0;
  int            compares = 0;

  // The clock toggles every half period of 12.5 ns.
  always #12.5 clk = ~clk;

  dvps_proc_model i_proc (.clock(clk), .code(code));

  dvps_top #(.NUM_PHASES(NP)) i_dut (
    .CLOCK(clk), .RST(rst), .EN_ABOVE_THRESHOLD(en), .SUPPLY_LOCKOUT(lock),
    .VOLTAGE_IDENT_CODE(code), .LOAD_STEP_UP(step), .LOAD_RELEASE(rel),
    .OUTPUT_IN_RANGE(inr), .OUTPUT_OVER_CLAMP(ovc), .PHASE_DRIVE(pd),
    .CORE_PHASE_DISABLE_N(core_n), .SHED_PHASE_DISABLE_N(shed_n),
    .OUTPUT_IN_RANGE_FLAG(flag), .CLAMP_ACTIVE(clamp), .LOAD_RELEASE_FLAG(rflag),
    .BLANKING_ACTIVE(blank), .CODE_TARGET(tgt));

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk_bit(input string name, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", name, e, g);
    end
  endtask

  task automatic chk_code(input string name, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask

  // Largest number of phases high together over six slots.
  task automatic max_on(output int m);
    m = 0;
    repeat (NP * dvps_pkg::SLOT_CYC) begin
      @(negedge clk);
      if ($countones(pd) > m) m = $countones(pd);
    end
  endtask

  // Signature of the firing order: each phase's slot offset from phase 0.
  task automatic grab_order(output int sig);
    int ord [NP];
    for (int p = 0; p < NP; p++) ord[p] = -1;
    for (int c = 0; c < 2 * NP * dvps_pkg::SLOT_CYC; c++) begin
      @(negedge clk);
      for (int p = 0; p < NP; p++) if (pd[p] === 1'b1 && ord[p] < 0) ord[p] = c;
    end
    sig = 0;
    for (int p = 0; p < NP; p++) sig = sig * 8 + ((ord[p] - ord[0] + 192 + 8) / 16) % NP;
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  // Outputs are low in reset; the start code becomes the target once running.
  task automatic t_reset();
    cyc(8);
    chk_bit("core_n_in_reset", 1'b0, core_n);
    chk_code("drive_in_reset", 8'h00, {2'b00, pd});
    rst = 1'b0;
    cyc(30);
    chk_bit("core_n_run", 1'b1, core_n);
    chk_bit("shed_n_run", 1'b1, shed_n);
    chk_code("start_target", 8'h40, tgt);
  endtask

  // A single step starts blanking at once and is ignored for the window, then taken.
  task automatic t_step();
    i_proc.step(8'h3c);
    cyc(5);
    chk_code("target_in_window", 8'h40, tgt);
    chk_bit("blank_started", 1'b1, blank);
    cyc(10);
    chk_code("target_taken", 8'h3c, tgt);
  endtask

  // Skewed bits never land an intermediate code; a late change extends blanking.
  task automatic t_skew();
    logic held;
    i_proc.walk(8'hc3, 4);
    cyc(4);
    chk_code("target_during_skew", 8'h3c, tgt);
    cyc(10);
    chk_code("target_after_skew", 8'hc3, tgt);
    held = flag;
    inr = 1'b0;
    ovc = 1'b1;
    cyc(6);
    chk_bit("flag_held_blanked", held, flag);
    chk_bit("clamp_blanked", 1'b0, clamp);
    cyc(3000);
    i_proc.step(8'h81);
    cyc(2000);
    chk_bit("blank_restarted", 1'b1, blank);
    cyc(2100);
    chk_bit("blank_ended", 1'b0, blank);
    chk_bit("flag_after_blank", 1'b0, flag);
    chk_bit("clamp_after_blank", 1'b1, clamp);
    inr = 1'b1;
    ovc = 1'b0;
    cyc(8);
  endtask

  // Step-up brings in every extra phase; removing it drops back to one.
  task automatic t_stepup();
    int m;
    max_on(m);
    chk_code("phases_idle_load", 8'd1, m[7:0]);
    step = 1'b1;
    cyc(40);
    max_on(m);
    chk_code("phases_step_up", 8'(NP), m[7:0]);
    step = 1'b0;
    cyc(6);
    max_on(m);
    chk_code("phases_after_step", 8'd1, m[7:0]);
  endtask

  // Each release raises the flag; the firing order changes across releases.
  task automatic t_release();
    int s0, s;
    logic changed;
    changed = 1'b0;
    grab_order(s0);
    for (int r = 0; r < 4; r++) begin
      rel = 1'b1;
      cyc(4);
      chk_bit("release_flag_on", 1'b1, rflag);
      rel = 1'b0;
      cyc(4);
      chk_bit("release_flag_off", 1'b0, rflag);
      grab_order(s);
      if (s != s0) changed = 1'b1;
    end
    chk_bit("order_shuffled", 1'b1, changed);
  endtask

  // An off code shuts down only after it stood for the confirm time.
  task automatic t_off();
    i_proc.step(dvps_pkg::OFF_CODE);
    cyc(100);
    chk_bit("core_n_confirming", 1'b1, core_n);
    cyc(120);
    chk_bit("core_n_shut", 1'b0, core_n);
    chk_code("drive_shut", 8'h00, {2'b00, pd});
    i_proc.step(8'h40);
    en = 1'b0;
    cyc(6);
    chk_bit("core_n_disabled", 1'b0, core_n);
    en = 1'b1;
    cyc(12);
    chk_bit("core_n_restart", 1'b1, core_n);
  endtask

  // Supply lockout forces drives, in-range flag and both driver enables low.
  task automatic t_lock();
    int m;
    lock = 1'b1;
    cyc(6);
    chk_bit("core_n_lockout", 1'b0, core_n);
    chk_bit("shed_n_lockout", 1'b0, shed_n);
    chk_bit("flag_lockout", 1'b0, flag);
    max_on(m);
    chk_code("drive_lockout", 8'd0, m[7:0]);
    lock = 1'b0;
  endtask

  // --------------------------------------------------------------------------
  // Run control
  // --------------------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence of scenarios.
  initial begin
    t_reset();
    t_step();
    t_skew();
    t_stepup();
    t_release();
    t_off();
    t_lock();
    results();
  end

  // Cuts a hang short well beyond the roughly 9000 cycles the scenarios need.
  initial begin
    #(25 * 30000);
    miscompares++;
    results();
  end
endmodule
